// ---- rtl/buck_fault_pkg.sv ----
/*
  shared constants and carrier types for the buck fault supervisor.
  assumes a 100 MHz system clock.
*/
package buck_fault_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // deglitch time in nanoseconds, nominal figure
  localparam int unsigned FILTER_NS = 10000;
  localparam int unsigned FILTER_CYCLES = (FILTER_NS * CLK_MHZ) / 1000;
  localparam int unsigned FAULT_W = 8;
  localparam int unsigned OVERCURRENT_BIT = 4;
  localparam int unsigned OVERTEMP_BIT = 5;
  localparam logic [7:0] FAULT_RESET = 8'h00;

  typedef struct packed {
    logic outputs_off;
    logic regulators_off;
    logic sequence_abort;
    logic sequence_restart;
  } shutdown_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SHUTDOWN = 2'b01,
    ST_RESTART = 2'b10
  } sup_state_t;
endpackage : buck_fault_pkg

// ---- rtl/deglitch_filter.sv ----
/*
  deglitch filter: synchronises a comparator and passes a level only
  after it has held steady for the set number of cycles.
  assumes the input is asynchronous to the clock.
*/
`timescale 1ns/1ns
module deglitch_filter #(
  parameter int unsigned CYCLES = 1000
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_raw,
  output logic o_level
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic sync_a;
  logic sync_b;
  logic [CW-1:0] count;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= i_raw;
      sync_b <= sync_a;
    end
  end

  // disabled filter drops to low, so stale heat does not carry over
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
      o_level <= 1'b0;
    end else if (!i_enable) begin
      count <= '0;
      o_level <= 1'b0;
    end else if (sync_b == o_level) begin
      count <= '0;
    end else if (count == CW'(CYCLES - 1)) begin
      count <= '0;
      o_level <= sync_b;
    end else begin
      count <= count + CW'(1);
    end
  end
endmodule : deglitch_filter

// ---- rtl/buck_fault_supervisor.sv ----
/*
  fault supervisor for the main buck supply: latches faults into the
  service fault register, shuts down on real overtemperature, restarts.

  what it holds:
  - two-flop synchronisers for the overcurrent and current limit pins
  - the thermal comparator, synchronised and deglitched by an instance
    of deglitch_filter
  - a three-state machine: run, shutdown, restart
  - registered shutdown levels for drivers, regulators and power-up
  - a one-cycle restart strobe towards the power-up sequencer
  - the service fault register: bit 4 overcurrent, bit 5 overtemperature,
    every other bit reads as zero

  timing, in cycles of the system clock:
  - overcurrent reaches bit 4 on the second edge after it is sampled
  - the thermal level needs FILTER_CYCLES steady cycles after its sync
  - the deglitch acts on both the rise and the fall of the comparator
  - bit 5 and the shutdown state follow the trip by one edge
  - the shutdown levels follow the state by one more edge
  - the restart strobe stands one cycle while the state returns to run
  - a read strobe clears both bits on the edge that samples it

  limitations:
  - heat seen while the buck is off in run state is forgotten, since
    the filter is held cleared then
  - recovery waits for the filtered comparator low, not for i_buck_on
  - shutdown lasts until the filtered comparator has fallen
  - a read and a new event in one cycle leave the bit set
  - the general output keep level is a constant; pump, CAN and general
    output are never switched here

  assumes comparators are asynchronous pins and the fault register read
  strobe comes from the serial interface on this clock.
  assumes i_buck_on comes from logic on this clock and needs no sync.
  assumes the power-up sequencer starts over from its first step on the
  restart strobe and holds off while the abort level stands.
*/
// How it works
// [R01] thermal comparator must stay stable 10 us before counting as event
// [R02] overcurrent while buck on latches bit 4, read clears it, no restart
// [R03] overtemperature without current limit does nothing
// [R04] overtemp with current limit disables all drivers except pump/CAN/gpo
// [R05] same case disables regulators, aborts power-up, latches bit 5
// [R06] once overtemperature clears, power-up sequence reruns from start
// [R07] faults are only evaluated while the buck regulator is on
`timescale 1ns/1ns
module buck_fault_supervisor #(
  parameter int unsigned FILTER_CYCLES = buck_fault_pkg::FILTER_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_buck_on,
  input wire logic i_overcurrent,
  input wire logic i_thermal_cmp,
  input wire logic i_current_limit,
  input wire logic i_fault_read,
  output logic [7:0] o_service_fault_register,
  output logic o_buck_overtemp_flag,
  output logic o_outputs_off,
  output logic o_regulators_off,
  output logic o_sequence_abort,
  output logic o_sequence_restart,
  output logic o_general_output_keep
);
  logic oc_a;
  logic oc_b;
  logic cl_a;
  logic cl_b;
  logic hot;
  logic trip;
  logic oc_evt;
  logic oc_fault;
  logic ot_fault;
  buck_fault_pkg::sup_state_t state;
  buck_fault_pkg::sup_state_t next_state;
  buck_fault_pkg::shutdown_t act;

  // two flops each; only the second is read
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oc_a <= 1'b0;
      oc_b <= 1'b0;
    end else begin
      oc_a <= i_overcurrent;
      oc_b <= oc_a;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cl_a <= 1'b0;
      cl_b <= 1'b0;
    end else begin
      cl_a <= i_current_limit;
      cl_b <= cl_a;
    end
  end

  // filter held cleared while the buck is off in run state
  deglitch_filter #(
    .CYCLES(FILTER_CYCLES)
  ) u_thermal (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_enable(i_buck_on || state != buck_fault_pkg::ST_RUN), // [R07]
    .i_raw(i_thermal_cmp),
    .o_level(hot) // [R01]
  );

  assign oc_evt = i_buck_on && oc_b; // [R07]
  // only heat plus current limit trips; heat alone is ignored
  assign trip = i_buck_on && hot && cl_b; // [R03] [R07]

  always_comb begin
    next_state = state;
    case (state)
      buck_fault_pkg::ST_RUN: begin
        if (trip) begin
          next_state = buck_fault_pkg::ST_SHUTDOWN;
        end
      end
      buck_fault_pkg::ST_SHUTDOWN: begin
        if (!hot) begin
          next_state = buck_fault_pkg::ST_RESTART; // [R06]
        end
      end
      buck_fault_pkg::ST_RESTART: begin
        next_state = buck_fault_pkg::ST_RUN;
      end
      default: begin
        next_state = buck_fault_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= buck_fault_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    act = '0;
    if (state == buck_fault_pkg::ST_SHUTDOWN) begin
      act.outputs_off = 1'b1; // [R04]
      act.regulators_off = 1'b1; // [R05]
      act.sequence_abort = 1'b1; // [R05]
    end
    act.sequence_restart = (state == buck_fault_pkg::ST_RESTART); // [R06]
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_outputs_off <= 1'b0;
    end else begin
      o_outputs_off <= act.outputs_off; // [R04]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_regulators_off <= 1'b0;
    end else begin
      o_regulators_off <= act.regulators_off; // [R05]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sequence_abort <= 1'b0;
    end else begin
      o_sequence_abort <= act.sequence_abort; // [R05]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sequence_restart <= 1'b0;
    end else begin
      o_sequence_restart <= act.sequence_restart; // [R06]
    end
  end

  // pump, CAN and general output stay alive through a shutdown
  assign o_general_output_keep = 1'b1; // [R04]

  // set wins over read-clear so an event in the read cycle survives
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oc_fault <=
        buck_fault_pkg::FAULT_RESET[buck_fault_pkg::OVERCURRENT_BIT];
    end else if (oc_evt) begin
      oc_fault <= 1'b1; // [R02]
    end else if (i_fault_read) begin
      oc_fault <= 1'b0; // [R02]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ot_fault <= buck_fault_pkg::FAULT_RESET[buck_fault_pkg::OVERTEMP_BIT];
    end else if (trip) begin
      ot_fault <= 1'b1; // [R05]
    end else if (i_fault_read) begin
      ot_fault <= 1'b0; // [R05]
    end
  end

  // spare bits stay at their reset value
  always_comb begin
    o_service_fault_register = buck_fault_pkg::FAULT_RESET;
    o_service_fault_register[buck_fault_pkg::OVERCURRENT_BIT] = oc_fault;
    o_service_fault_register[buck_fault_pkg::OVERTEMP_BIT] = ot_fault;
  end

  assign o_buck_overtemp_flag =
    o_service_fault_register[buck_fault_pkg::OVERTEMP_BIT];
endmodule : buck_fault_supervisor

// ---- test/buck_fault_chk.sv ----
/* assertions on the buck fault supervisor ports.
   assumes it is bound to every instance of that module. */
`timescale 1ns/1ns
module buck_fault_chk #(
  parameter int unsigned FILTER_CYCLES = buck_fault_pkg::FILTER_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_buck_on,
  input wire logic i_overcurrent,
  input wire logic i_thermal_cmp,
  input wire logic i_current_limit,
  input wire logic i_fault_read,
  input wire logic [7:0] o_service_fault_register,
  input wire logic o_buck_overtemp_flag,
  input wire logic o_outputs_off,
  input wire logic o_regulators_off,
  input wire logic o_sequence_abort,
  input wire logic o_sequence_restart,
  input wire logic o_general_output_keep
);
  int hi_run;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // run length of thermal high; sync delay gives the slack
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n) hi_run <= 0;
    else hi_run <= i_thermal_cmp ? hi_run + 1 : 0;
  deglitch_a: assert property (
    $rose(o_buck_overtemp_flag) |-> hi_run > FILTER_CYCLES
    && hi_run <= FILTER_CYCLES + 6) else $error("trip timing");
  oc_latch_a: assert property (
    $past(i_rst_n, 2) && $past(i_overcurrent, 2) && i_buck_on
    |=> o_service_fault_register[4]) else $error("bit4 missing");
  read_clear_a: assert property (
    i_fault_read && !i_buck_on |=> o_service_fault_register == 8'h00)
    else $error("read kept bits");
  heat_alone_a: assert property (
    !i_current_limit [*6] |-> !$rose(o_buck_overtemp_flag))
    else $error("trip without limit");
  shut_all_a: assert property (
    o_outputs_off |-> o_regulators_off && o_sequence_abort
    && o_general_output_keep) else $error("partial shutdown");
  shut_follow_a: assert property (
    $rose(o_buck_overtemp_flag) && !o_outputs_off |=> o_outputs_off)
    else $error("no shutdown");
  restart_a: assert property (
    $fell(o_outputs_off) |-> o_sequence_restart)
    else $error("no restart");
  buck_off_a: assert property (
    !$past(i_buck_on) |-> !$rose(o_service_fault_register[4]))
    else $error("fault while off");
endmodule : buck_fault_chk
bind buck_fault_supervisor buck_fault_chk #(
  .FILTER_CYCLES(FILTER_CYCLES)
) buck_fault_chk_inst (
  .i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n),
  .i_buck_on(i_buck_on),
  .i_overcurrent(i_overcurrent),
  .i_thermal_cmp(i_thermal_cmp),
  .i_current_limit(i_current_limit),
  .i_fault_read(i_fault_read),
  .o_service_fault_register(o_service_fault_register),
  .o_buck_overtemp_flag(o_buck_overtemp_flag),
  .o_outputs_off(o_outputs_off),
  .o_regulators_off(o_regulators_off),
  .o_sequence_abort(o_sequence_abort),
  .o_sequence_restart(o_sequence_restart),
  .o_general_output_keep(o_general_output_keep)
);

// ---- test/testbench.sv ----
/* self-checking bench for the buck fault supervisor.
   assumes a short filter of 8 cycles at 100 MHz. */
`timescale 1ns/1ns
module testbench;
  logic i_clk_sys = 0, i_rst_n = 0, i_buck_on = 0, i_overcurrent = 0;
  logic i_thermal_cmp = 0, i_current_limit = 0, i_fault_read = 0;
  logic [7:0] o_service_fault_register;
  logic o_buck_overtemp_flag, o_outputs_off, o_regulators_off;
  logic o_sequence_abort, o_sequence_restart, o_general_output_keep;
  int n_fail = 0, compares = 0, cyc = 0;
  buck_fault_supervisor #(.FILTER_CYCLES(8)) buck_fault_supervisor_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_buck_on(i_buck_on),
    .i_overcurrent(i_overcurrent),
    .i_thermal_cmp(i_thermal_cmp),
    .i_current_limit(i_current_limit),
    .i_fault_read(i_fault_read),
    .o_service_fault_register(o_service_fault_register),
    .o_buck_overtemp_flag(o_buck_overtemp_flag),
    .o_outputs_off(o_outputs_off),
    .o_regulators_off(o_regulators_off),
    .o_sequence_abort(o_sequence_abort),
    .o_sequence_restart(o_sequence_restart),
    .o_general_output_keep(o_general_output_keep)
  );
  initial forever #5 i_clk_sys = ~i_clk_sys;
  // hang guard; run needs about a hundred cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic read_reg();
    i_fault_read = 1;
    tick(1);
    i_fault_read = 0;
    tick(1);
  endtask : read_reg
  task automatic oc_on();
    i_buck_on = 1;
    i_overcurrent = 1;
    tick(1);
    i_overcurrent = 0;
    tick(4);
    chk("bit4", o_service_fault_register, 8'h10);
    chk("no restart", {o_outputs_off, o_sequence_restart}, 8'h00);
    read_reg();
    chk("bit4 clr", o_service_fault_register, 8'h00);
  endtask : oc_on
  task automatic oc_off();
    i_buck_on = 0;
    i_overcurrent = 1;
    tick(5);
    i_overcurrent = 0;
    // let the sync flops drain before the buck comes back on
    tick(3);
    chk("off", o_service_fault_register, 8'h00);
  endtask : oc_off
  task automatic heat_only();
    i_buck_on = 1;
    i_thermal_cmp = 1;
    tick(20);
    chk("heat", {o_outputs_off, o_service_fault_register[6:0]},
      8'h00);
    i_thermal_cmp = 0;
    tick(12);
  endtask : heat_only
  task automatic glitch();
    i_current_limit = 1;
    i_thermal_cmp = 1;
    tick(5);
    i_thermal_cmp = 0;
    tick(12);
    chk("glitch", o_service_fault_register, 8'h00);
  endtask : glitch
  task automatic trip();
    i_thermal_cmp = 1;
    tick(9);
    chk("early", o_service_fault_register, 8'h00);
    tick(6);
    chk("bit5", o_service_fault_register, 8'h20);
    chk("shut", {o_buck_overtemp_flag, o_outputs_off, o_regulators_off,
      o_sequence_abort, o_general_output_keep}, 8'h1F);
    i_thermal_cmp = 0;
    i_current_limit = 0;
    repeat (30) if (o_sequence_restart !== 1'b1) tick(1);
    chk("restart", {o_sequence_restart, o_outputs_off}, 8'h02);
    tick(1);
    chk("pulse", {o_sequence_restart, o_regulators_off}, 8'h00);
    i_buck_on = 0;
    read_reg();
    chk("bit5 clr", o_service_fault_register, 8'h00);
  endtask : trip
  task automatic results();
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    tick(3);
    i_rst_n = 1;
    chk("reset", {o_general_output_keep, o_outputs_off}, 8'h02);
    oc_on();
    oc_off();
    heat_only();
    glitch();
    trip();
    results();
  end
endmodule : testbench
